// ### core/mb_filter_consts.vh
// Purpose: shared constants for the message buffer slot filter
// Assumes: included by core/msg_buffer_slot_filter.v
// Notes: state codes of the host-side buffer view
`ifndef MB_FILTER_CONSTS_VH
`define MB_FILTER_CONSTS_VH
`define MBF_NUM_BUF 8
`define MBF_SLOT_W 11
`define MBF_CYC_W 6
`define MBF_IDX_W 3
`define MBF_HIDX_W 7
`define MBF_DEPTH_W 8
`define MBF_SIZE_W 7
`define MBF_ST_W 2
// host view states of a buffer
`define MBF_ST_ENABLED 2'h0
`define MBF_ST_HOST_DISABLED_STATE 2'h1
`define MBF_ST_HOST_DISABLED_STATE_LCK 2'h2
// search sequencer states
`define MBF_S_IDLE 2'h0
`define MBF_S_SCAN 2'h1
`define MBF_S_DONE 2'h2
// reset values
`define MBF_RST_SLOT 11'h000
`define MBF_RST_CYC 6'h00
`define MBF_RST_HIDX 7'h00
`define MBF_RST_DEPTH 8'h00
`define MBF_RST_SIZE 7'h00
`endif

// ### core/msg_buffer_slot_filter.v
// Purpose: per-buffer slot id and cycle filters, channel split, reconfig gating, rx queue areas
// Assumes: one clock, synchronous active high reset, inputs synchronous to clk_sys
// Notes: configuration is written one buffer at a time through cfg_* ports
// Contract
// - each buffer is filtered by slot id first, then cycle filter
// - slot id filter matches when stored slot id equals search slot and buffer is enabled, one search slot for both channels
// - no buffer is listed without a slot id match
// - every transmit buffer with slot id match is listed
// - receive buffers listed only when slot id and cycle filter both match
// - disabled cycle filter matches every cycle
// - transmit buffer failing cycle filter listed with cycle match flag zero
// - cycle filter compares masked cycle number to masked value, bits 5..0
// - link a select and link b select choose channels, both allowed
// - buffer fields writable in protocol config state, otherwise only as the rules below allow; common data only in protocol config state
// - same basic type: singles in disabled states, doubles both sides host disabled
// - same buffer type change only for singles in either disabled state
// - type change needs even/odd pair, all involved buffers host disabled
// - two independent receive queues, one per channel
// - queue area is start index plus entry count and entry size
// - best priority group, lowest buffer number wins
`timescale 1ns/1ps
`include "mb_filter_consts.vh"
module msg_buffer_slot_filter #(
   parameter NB = `MBF_NUM_BUF,
   parameter IW = `MBF_IDX_W
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire protocol_config_state,
   input wire search_start,
   input wire [`MBF_SLOT_W-1:0] search_slot,
   input wire [`MBF_CYC_W-1:0] cycle_number,
   input wire [NB*`MBF_ST_W-1:0] buf_state,
   input wire [NB-1:0] buf_committed,
   input wire [NB-1:0] buf_locked,
   input wire cfg_we,
   input wire [IW-1:0] cfg_idx,
   input wire [`MBF_SLOT_W-1:0] cfg_slot_id_field,
   input wire cfg_cycle_filter_enable,
   input wire [`MBF_CYC_W-1:0] cfg_cycle_filter_mask,
   input wire [`MBF_CYC_W-1:0] cfg_cycle_filter_value,
   input wire cfg_link_a_select,
   input wire cfg_link_b_select,
   input wire cfg_transfer_direction_bit,
   input wire cfg_buffer_type_bit,
   input wire cfg_enable,
   input wire rxq_we,
   input wire rxq_sel,
   input wire [`MBF_HIDX_W-1:0] rxq_start_index,
   input wire [`MBF_DEPTH_W-1:0] rxq_depth,
   input wire [`MBF_SIZE_W-1:0] rxq_entry_size,
   output reg cfg_rejected,
   output reg search_done,
   output reg [NB-1:0] match_a,
   output reg [NB-1:0] match_b,
   output reg [NB-1:0] cycle_filter_match,
   output reg found_a,
   output reg [IW-1:0] result_a,
   output reg [2:0] prio_a,
   output reg found_b,
   output reg [IW-1:0] result_b,
   output reg [2:0] prio_b,
   output reg [`MBF_HIDX_W-1:0] rxq_a_start_q,
   output reg [`MBF_DEPTH_W-1:0] rxq_a_depth_q,
   output reg [`MBF_SIZE_W-1:0] rxq_a_size_q,
   output reg [`MBF_HIDX_W-1:0] rxq_b_start_q,
   output reg [`MBF_DEPTH_W-1:0] rxq_b_depth_q,
   output reg [`MBF_SIZE_W-1:0] rxq_b_size_q
);
   // per-buffer configuration storage
   reg [`MBF_SLOT_W-1:0] slot_id_q [0:NB-1];
   reg [`MBF_CYC_W-1:0] cf_mask_q [0:NB-1];
   reg [`MBF_CYC_W-1:0] cf_value_q [0:NB-1];
   reg [NB-1:0] cf_en_q;
   reg [NB-1:0] cha_q;
   reg [NB-1:0] chb_q;
   reg [NB-1:0] dir_q;
   reg [NB-1:0] dbl_q;
   reg [NB-1:0] en_q;
   reg [1:0] seq_q;
   reg [`MBF_SLOT_W-1:0] slot_q;
   reg [`MBF_CYC_W-1:0] cyc_q;
   reg [IW:0] scan_q;
   reg [2:0] best_pa_q;
   reg [2:0] best_pb_q;
   wire [NB-1:0] id_hit;
   wire [NB-1:0] cyc_hit;
   wire [NB-1:0] listed;
   wire [NB-1:0] st_host_disabled_state;
   wire [NB-1:0] st_any_dis;
   genvar g;
   integer i;

   // filters per buffer
   generate
      for (g = 0; g < NB; g = g + 1) begin : g_filt
         assign id_hit[g] = en_q[g] && (slot_id_q[g] == slot_q);
         assign cyc_hit[g] = !cf_en_q[g] ||
            ((cyc_q & cf_mask_q[g]) == (cf_value_q[g] & cf_mask_q[g]));
         assign listed[g] = id_hit[g] && (dir_q[g] || cyc_hit[g]);
         assign st_host_disabled_state[g] = buf_state[g*`MBF_ST_W +: `MBF_ST_W] == `MBF_ST_HOST_DISABLED_STATE;
         assign st_any_dis[g] = st_host_disabled_state[g] ||
            (buf_state[g*`MBF_ST_W +: `MBF_ST_W] == `MBF_ST_HOST_DISABLED_STATE_LCK);
      end
   endgenerate

   // priority of one listed buffer, 0 best, 5 means not listed
   function [2:0] prio_of;
      input lst;
      input dir;
      input cfm;
      input lck;
      input cmt;
      begin
         if (!lst)
            prio_of = 3'h5;
         else if (dir && !cfm)
            prio_of = 3'h2;
         else if (dir)
            prio_of = (!lck && cmt) ? 3'h0 : 3'h1;
         else
            prio_of = lck ? 3'h4 : 3'h3;
      end
   endfunction

   // reconfiguration permission for the addressed buffer
   reg allow;
   reg [IW-1:0] mate;
   reg is_dbl;
   always @* begin
      allow = 1'b0;
      is_dbl = dbl_q[cfg_idx];
      mate = cfg_idx ^ {{(IW-1){1'b0}}, 1'b1};
      if (protocol_config_state) begin
         allow = 1'b1;
      end else if (cfg_buffer_type_bit != dbl_q[cfg_idx]) begin
         // pair must be even/odd and both sides host disabled
         allow = st_host_disabled_state[cfg_idx] && st_host_disabled_state[mate];
      end else if (cfg_transfer_direction_bit == dir_q[cfg_idx]) begin
         if (is_dbl)
            allow = st_host_disabled_state[cfg_idx] && st_host_disabled_state[mate];
         else
            allow = st_any_dis[cfg_idx];
      end else begin
         allow = !is_dbl && st_any_dis[cfg_idx];
      end
   end

   // configuration write; double buffers always span an even/odd pair
   always @(posedge clk_sys) begin
      if (rst) begin
         cfg_rejected <= 1'b0;
         cf_en_q <= {NB{1'b0}};
         cha_q <= {NB{1'b0}};
         chb_q <= {NB{1'b0}};
         dir_q <= {NB{1'b0}};
         dbl_q <= {NB{1'b0}};
         en_q <= {NB{1'b0}};
         for (i = 0; i < NB; i = i + 1) begin
            slot_id_q[i] <= `MBF_RST_SLOT;
            cf_mask_q[i] <= `MBF_RST_CYC;
            cf_value_q[i] <= `MBF_RST_CYC;
         end
      end else if (ce) begin
         cfg_rejected <= cfg_we && !allow;
         if (cfg_we && allow) begin
            slot_id_q[cfg_idx] <= cfg_slot_id_field;
            cf_en_q[cfg_idx] <= cfg_cycle_filter_enable;
            cf_mask_q[cfg_idx] <= cfg_cycle_filter_mask;
            cf_value_q[cfg_idx] <= cfg_cycle_filter_value;
            cha_q[cfg_idx] <= cfg_link_a_select;
            chb_q[cfg_idx] <= cfg_link_b_select;
            dir_q[cfg_idx] <= cfg_transfer_direction_bit;
            en_q[cfg_idx] <= cfg_enable;
            dbl_q[cfg_idx] <= cfg_buffer_type_bit;
            dbl_q[mate] <= cfg_buffer_type_bit;
         end
      end
   end

   // receive queue areas, common data only written in protocol config state
   always @(posedge clk_sys) begin
      if (rst) begin
         rxq_a_start_q <= `MBF_RST_HIDX;
         rxq_a_depth_q <= `MBF_RST_DEPTH;
         rxq_a_size_q <= `MBF_RST_SIZE;
         rxq_b_start_q <= `MBF_RST_HIDX;
         rxq_b_depth_q <= `MBF_RST_DEPTH;
         rxq_b_size_q <= `MBF_RST_SIZE;
      end else if (ce && rxq_we && protocol_config_state) begin
         if (!rxq_sel) begin
            rxq_a_start_q <= rxq_start_index;
            rxq_a_depth_q <= rxq_depth;
            rxq_a_size_q <= rxq_entry_size;
         end else begin
            rxq_b_start_q <= rxq_start_index;
            rxq_b_depth_q <= rxq_depth;
            rxq_b_size_q <= rxq_entry_size;
         end
      end
   end

   // sequential search, one buffer per cycle, ascending number
   reg [IW-1:0] k;
   reg [2:0] p;
   always @* begin
      k = scan_q[IW-1:0];
      p = prio_of(listed[k], dir_q[k], cyc_hit[k] || !dir_q[k],
                  buf_locked[k], buf_committed[k]);
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         seq_q <= `MBF_S_IDLE;
         slot_q <= `MBF_RST_SLOT;
         cyc_q <= `MBF_RST_CYC;
         scan_q <= {(IW+1){1'b0}};
         best_pa_q <= 3'h5;
         best_pb_q <= 3'h5;
         search_done <= 1'b0;
         match_a <= {NB{1'b0}};
         match_b <= {NB{1'b0}};
         cycle_filter_match <= {NB{1'b0}};
         found_a <= 1'b0;
         found_b <= 1'b0;
         result_a <= {IW{1'b0}};
         result_b <= {IW{1'b0}};
         prio_a <= 3'h5;
         prio_b <= 3'h5;
      end else if (ce) begin
         search_done <= 1'b0;
         if (search_start) begin
            // a new start aborts any running scan
            seq_q <= `MBF_S_SCAN;
            slot_q <= search_slot;
            cyc_q <= cycle_number;
            scan_q <= {(IW+1){1'b0}};
            best_pa_q <= 3'h5;
            best_pb_q <= 3'h5;
            match_a <= {NB{1'b0}};
            match_b <= {NB{1'b0}};
            cycle_filter_match <= {NB{1'b0}};
            found_a <= 1'b0;
            found_b <= 1'b0;
         end else begin
            case (seq_q)
               `MBF_S_SCAN: begin
                  match_a[k] <= listed[k] && cha_q[k];
                  match_b[k] <= listed[k] && chb_q[k];
                  // a buffer on neither channel is in no list, so it gets no flag
                  cycle_filter_match[k] <= listed[k] && cyc_hit[k] &&
                     (cha_q[k] || chb_q[k]);
                  // strict compare keeps the lowest number in a group
                  if (listed[k] && cha_q[k] && p < best_pa_q) begin
                     best_pa_q <= p;
                     found_a <= 1'b1;
                     result_a <= k;
                  end
                  if (listed[k] && chb_q[k] && p < best_pb_q) begin
                     best_pb_q <= p;
                     found_b <= 1'b1;
                     result_b <= k;
                  end
                  if (scan_q == NB - 1)
                     seq_q <= `MBF_S_DONE;
                  scan_q <= scan_q + {{IW{1'b0}}, 1'b1};
               end
               `MBF_S_DONE: begin
                  prio_a <= best_pa_q;
                  prio_b <= best_pb_q;
                  search_done <= 1'b1;
                  seq_q <= `MBF_S_IDLE;
               end
               default: seq_q <= `MBF_S_IDLE;
            endcase
         end
      end
   end
endmodule // msg_buffer_slot_filter

// ### dv/mbf_monitor.sv
// Purpose: port checker for the slot filter
// Assumes: bound to msg_buffer_slot_filter, one clock domain
// Notes: search results are judged at the search_done pulse
`timescale 1ns/1ps
module mbf_monitor #(
   parameter NB = 8,
   parameter IW = 3
) (
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire protocol_config_state,
   input wire search_start,
   input wire cfg_we,
   input wire rxq_we,
   input wire rxq_sel,
   input wire [6:0] rxq_start_index,
   input wire cfg_rejected,
   input wire search_done,
   input wire [NB-1:0] match_a,
   input wire [NB-1:0] match_b,
   input wire [NB-1:0] cycle_filter_match,
   input wire found_a,
   input wire [IW-1:0] result_a,
   input wire [2:0] prio_a,
   input wire [6:0] rxq_a_start_q,
   input wire [6:0] rxq_b_start_q
);
   localparam int DMIN = NB + 2;
   localparam int DMAX = NB + 2;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // search sequencing and list contents
   property p_clear; ce && search_start |=> (match_a | match_b) == 0; endproperty
   a_clear: assert property (p_clear) else $error("lists not cleared at search start");
   property p_done; ce && search_start |-> ##[DMIN:DMAX] search_done; endproperty
   a_done: assert property (p_done) else $error("search did not complete in time");
   property p_pulse; search_done |=> !search_done; endproperty
   a_pulse: assert property (p_pulse) else $error("search_done longer than one cycle");
   property p_pick; search_done |-> found_a == (|match_a) && (!found_a || match_a[result_a]);
   endproperty
   a_pick: assert property (p_pick) else $error("result not from match list");
   property p_none; search_done && !found_a |-> prio_a == 3'h5; endproperty
   a_none: assert property (p_none) else $error("empty list without none priority");
   property p_cfm; search_done |-> (cycle_filter_match & ~(match_a | match_b)) == 0; endproperty
   a_cfm: assert property (p_cfm) else $error("cycle match on unlisted buffer");
   // configuration gating
   property p_rej; cfg_rejected && $past(ce) |-> $past(cfg_we) && !$past(protocol_config_state);
   endproperty
   a_rej: assert property (p_rej) else $error("refusal without reconfig write");
   property p_lock; ce && rxq_we && !protocol_config_state |=> $stable(rxq_a_start_q) &&
      $stable(rxq_b_start_q); endproperty
   a_lock: assert property (p_lock) else $error("queue area changed outside config");
   property p_rxa; ce && rxq_we && protocol_config_state && !rxq_sel |=>
      rxq_a_start_q == $past(rxq_start_index) && $stable(rxq_b_start_q); endproperty
   a_rxa: assert property (p_rxa) else $error("queue a write wrong");
   c_done: cover property (search_done && found_a);
   c_rej: cover property (cfg_rejected);
   c_rxq: cover property (rxq_we && protocol_config_state);
endmodule // mbf_monitor
bind msg_buffer_slot_filter mbf_monitor #(.NB(NB), .IW(IW)) u_mon (.*);

// ### dv/host_proto_model.sv
// Purpose: host and protocol engine view of buffer states
// Assumes: driven by task calls from the bench
// Notes: buffers are moved to disabled states before reconfiguration
`timescale 1ns/1ps
module host_proto_model #(
   parameter NB = 8
) (
   input wire clk_sys,
   output logic [2*NB-1:0] buf_state,
   output logic [NB-1:0] buf_committed,
   output logic [NB-1:0] buf_locked
);
   // all buffers enabled, uncommitted, unlocked
   initial begin
      buf_state = '0;
      buf_committed = '0;
      buf_locked = '0;
   end
   // state change just after an edge
   task automatic set_state(input int i, input logic [1:0] s);
      @(posedge clk_sys);
      buf_state[2*i +: 2] <= s;
   endtask
   // commit and lock flags just after an edge
   task automatic set_flags(input logic [NB-1:0] c, input logic [NB-1:0] l);
      @(posedge clk_sys);
      buf_committed <= c;
      buf_locked <= l;
   endtask
endmodule // host_proto_model

// ### dv/tb_top.sv
// Purpose: directed bench for the slot filter
// Assumes: design default of 8 buffers
// Notes: flags are {cycle filter on, link a, link b, tx, double, enable}
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic protocol_config_state = 1'b1;
   logic search_start = 1'b0, cfg_we = 1'b0, rxq_we = 1'b0, rxq_sel = 1'b0;
   logic [10:0] search_slot = 11'h000, cfg_slot_id_field = 11'h000;
   logic [5:0] cycle_number = 6'h00, cfg_cycle_filter_mask = 6'h00, cfg_cycle_filter_value = 6'h00;
   logic cfg_cycle_filter_enable = 1'b0, cfg_link_a_select = 1'b0, cfg_link_b_select = 1'b0;
   logic cfg_transfer_direction_bit = 1'b0, cfg_buffer_type_bit = 1'b0, cfg_enable = 1'b0;
   logic [2:0] cfg_idx = 3'h0;
   logic [6:0] rxq_start_index = 7'h00, rxq_entry_size = 7'h00;
   logic [7:0] rxq_depth = 8'h00;
   logic [15:0] buf_state;
   logic [7:0] buf_committed, buf_locked, match_a, match_b, cycle_filter_match;
   logic cfg_rejected, search_done, found_a, found_b;
   logic [2:0] result_a, prio_a, result_b, prio_b;
   logic [6:0] rxq_a_start_q, rxq_a_size_q, rxq_b_start_q, rxq_b_size_q;
   logic [7:0] rxq_a_depth_q, rxq_b_depth_q;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   msg_buffer_slot_filter dut (.*);
   host_proto_model #(.NB(8)) u_host (.*);
   // clock and hang guard
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // one buffer write, refusal flag checked the cycle after
   task automatic cfg(input logic [2:0] i, input logic [10:0] sl, input logic [5:0] m, v, f,
                      input logic erj);
      @(posedge clk_sys);
      cfg_we <= 1'b1;
      cfg_idx <= i;
      cfg_slot_id_field <= sl;
      cfg_cycle_filter_mask <= m;
      cfg_cycle_filter_value <= v;
      {cfg_cycle_filter_enable, cfg_link_a_select, cfg_link_b_select,
       cfg_transfer_direction_bit, cfg_buffer_type_bit, cfg_enable} <= f;
      @(posedge clk_sys);
      cfg_we <= 1'b0;
      #1 chk("cfg_rejected", cfg_rejected, erj);
   endtask
   // one search, waits for done, then checks the lists
   task automatic srch(input logic [10:0] sl, input logic [5:0] cy, input logic [23:0] e);
      @(posedge clk_sys);
      search_start <= 1'b1;
      search_slot <= sl;
      cycle_number <= cy;
      @(posedge clk_sys);
      search_start <= 1'b0;
      repeat (20) begin
         @(posedge clk_sys);
         #1;
         if (search_done === 1'b1) break;
      end
      chk("search_done", search_done, 1'b1);
      chk("lists", {match_a, match_b, cycle_filter_match}, e);
   endtask
   // one queue area write, then one idle cycle
   task automatic rq(input logic s, input logic [6:0] st, input logic [7:0] dp,
                     input logic [6:0] sz);
      @(posedge clk_sys);
      {rxq_we, rxq_sel, rxq_start_index, rxq_depth, rxq_entry_size} <= {1'b1, s, st, dp, sz};
      @(posedge clk_sys);
      rxq_we <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      cfg(3'h0, 11'h005, 6'h03, 6'h01, 6'h35, 1'b0);
      cfg(3'h1, 11'h005, 6'h03, 6'h01, 6'h31, 1'b0);
      cfg(3'h2, 11'h005, 6'h00, 6'h00, 6'h11, 1'b0);
      cfg(3'h3, 11'h009, 6'h00, 6'h00, 6'h19, 1'b0);
      cfg(3'h4, 11'h006, 6'h00, 6'h00, 6'h0D, 1'b0);
      srch(11'h005, 6'h05, 24'h070007);
      chk("pick_a", {found_a, result_a, prio_a}, 7'h41);
      srch(11'h005, 6'h06, 24'h050004);
      chk("pick_a", {found_a, result_a, prio_a}, 7'h42);
      srch(11'h009, 6'h00, 24'h080808);
      chk("pick_b", {found_b, result_b, prio_b}, 7'h5B);
      u_host.set_flags(8'h01, 8'h08);
      srch(11'h005, 6'h05, 24'h070007);
      chk("pick_a", {found_a, result_a, prio_a}, 7'h40);
      srch(11'h009, 6'h00, 24'h080808);
      chk("pick_b", {found_b, result_b, prio_b}, 7'h5C);
      u_host.set_flags(8'h00, 8'h00);
      srch(11'h006, 6'h00, 24'h001010);
      chk("none_a", {found_a, prio_a}, 4'h5);
      srch(11'h007, 6'h00, 24'h000000);
      srch(11'h000, 6'h00, 24'h000000);
      rq(1'b0, 7'h10, 8'h04, 7'h20);
      rq(1'b1, 7'h30, 8'h02, 7'h08);
      chk("rxq_a", {rxq_a_start_q, rxq_a_depth_q, rxq_a_size_q}, {7'h10, 8'h04, 7'h20});
      chk("rxq_b", {rxq_b_start_q, rxq_b_depth_q, rxq_b_size_q}, {7'h30, 8'h02, 7'h08});
      protocol_config_state <= 1'b0;
      rq(1'b0, 7'h55, 8'h09, 7'h11);
      chk("rxq_a", {rxq_a_start_q, rxq_a_depth_q, rxq_a_size_q}, {7'h10, 8'h04, 7'h20});
      cfg(3'h1, 11'h007, 6'h00, 6'h00, 6'h11, 1'b1);
      u_host.set_state(1, 2'h2);
      cfg(3'h1, 11'h007, 6'h00, 6'h00, 6'h11, 1'b0);
      srch(11'h007, 6'h00, 24'h020002);
      // a frozen block takes no write
      @(posedge clk_sys);
      ce <= 1'b0;
      cfg(3'h1, 11'h009, 6'h00, 6'h00, 6'h11, 1'b0);
      ce <= 1'b1;
      srch(11'h007, 6'h00, 24'h020002);
      cfg(3'h2, 11'h005, 6'h00, 6'h00, 6'h15, 1'b1);
      u_host.set_state(2, 2'h2);
      cfg(3'h2, 11'h005, 6'h00, 6'h00, 6'h15, 1'b0);
      cfg(3'h1, 11'h007, 6'h00, 6'h00, 6'h17, 1'b1);
      u_host.set_state(0, 2'h1);
      u_host.set_state(1, 2'h1);
      cfg(3'h1, 11'h007, 6'h00, 6'h00, 6'h17, 1'b0);
      // a double buffer needs both sides host disabled
      cfg(3'h0, 11'h007, 6'h00, 6'h00, 6'h17, 1'b0);
      u_host.set_state(1, 2'h2);
      cfg(3'h0, 11'h007, 6'h00, 6'h00, 6'h17, 1'b1);
      give_verdict();
   end
endmodule // tb_top
